//--- ire_event_status.sv
// Summary of operation
// R1: The raw flag word always shows the true event state with no mask applied.
// R2: The restart flag sets on a repeated start while addressed as slave, if enabled.
// R3: No restart flag when the repeated start precedes the address (high speed, start byte).
// R4: The broadcast-call flag sets only when the general call is received and acknowledged.
// R5: The broadcast-call flag holds until disable or a read of its clear register; the code also clears it on a read of the combined clear register.
// R6: Bytes received after an acknowledged general call go to the receive buffer.
// R7: The start flag sets on any start or repeated start, master or slave.
// R8: The stop flag sets on a stop condition in master and slave operation, as qualified.
// R9: Slave with config bit 7 set flags a stop only if it was addressed.
// R10: With that option a general call alone never qualifies a stop.
// R11: Slave with config bit 7 clear flags every stop.
// R12: Master with config bit 10 set flags a stop only while its master is active; the code also flags it if the master was active earlier in the transfer.
// R13: Master with config bit 10 clear flags every stop.
// R14: The activity flag sets on any activity and holds after return to idle.
// R15: Activity clears only on disable, clear reads, or system reset.
// R16: The transmit-finished flag sets when a slave-transmitted byte is not acknowledged.
// R17: The mask is active low: a zero hides the flag from the masked view.
//
// Added by the designer: the AHB-Lite slave port.
module ire_event_status (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic      [31:0]          hrdata,
   output logic                      hreadyout,
   output logic                      hresp,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   input  ire_pkg::ire_engine_t      engine,
   output logic                      rx_push,
   output logic      [7:0]           rx_byte
);
   import ire_pkg::*;

   ire_bus_ev_t           bus_ev;
   ire_flags_t            flags_r;
   ire_flags_t            flags_set;
   logic [FLAG_W-1:0]     raw_word;
   logic [FLAG_W-1:0]     mask_r;
   logic [CTRL_W-1:0]     ctrl_r;
   logic                  enable_r;
   logic                  rst_en_r;
   logic                  addressed_r;
   logic                  mact_seen_r;
   logic                  gc_sess_r;
   logic                  rd_acc;
   logic                  wr_acc;
   logic                  wr_pend_r;
   logic [7:0]            wr_addr_r;
   logic [7:0]            acc_addr;
   logic                  clr_all;
   logic                  clr_act;
   logic                  clr_gc;
   logic                  stop_ok;
   logic [31:0]           rd_data;
   logic [31:0]           hrdata_r;
   logic                  hreadyout_r;
   logic                  hresp_r;
   logic                  rx_push_r;
   logic [7:0]            rx_byte_r;

   // Start, stop and busy seen on the synchronised bus lines
   ire_bus_monitor u_mon (
      .hclk    (hclk),
      .hresetn (hresetn),
      .scl_in  (scl_in),
      .sda_in  (sda_in),
      .bus_ev  (bus_ev)
   );

   // Bus request decode; only whole-word singles are expected, size ignored
   assign acc_addr = haddr[7:0];
   assign rd_acc   = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;
   assign wr_acc   = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;

   // Clear-on-read strobes, taken in the address phase of the read
   assign clr_all = rd_acc && (acc_addr == ADDR_CLR_ALL);
   assign clr_act = rd_acc && (acc_addr == ADDR_CLR_ACT);
   assign clr_gc  = rd_acc && (acc_addr == ADDR_CLR_GC);

   // Per-transfer memory: addressed by own address, master busy, general call
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addressed_r <= 1'b0;
         mact_seen_r <= 1'b0;
         gc_sess_r   <= 1'b0;
      end else if (!enable_r || bus_ev.stop) begin
         addressed_r <= 1'b0;
         mact_seen_r <= 1'b0;
         gc_sess_r   <= 1'b0;
      end else begin
         if (engine.own_addr_match) begin
            addressed_r <= 1'b1; // R10
         end
         if (engine.master_active) begin
            mact_seen_r <= 1'b1;
         end
         if (engine.broadcast_call_flag_ack) begin
            gc_sess_r <= 1'b1;
         end
      end
   end

   // Stop qualification by mode and configuration
   always_comb begin
      if (engine.master_mode) begin
         stop_ok = !ctrl_r[CTRL_STOP_MACT]                   // R13
                   || mact_seen_r || engine.master_active;   // R12
      end else begin
         stop_ok = !ctrl_r[CTRL_STOP_ADDR]                   // R11
                   || addressed_r;                           // R9 R10
      end
   end

   // Set terms, all gated by the controller enable
   always_comb begin
      flags_set.restart  = enable_r && bus_ev.restart && !engine.master_mode
                           && rst_en_r                       // R2
                           && addressed_r
                           && !engine.addr_after_restart;    // R3
      flags_set.broadcast_call_flag = enable_r && engine.broadcast_call_flag_ack;  // R4
      flags_set.start    = enable_r && bus_ev.start;         // R7
      flags_set.stop     = enable_r && bus_ev.stop && stop_ok; // R8
      flags_set.activity = enable_r && (bus_ev.start || bus_ev.busy
                           || engine.master_active);         // R14
      flags_set.tx_done  = enable_r && !engine.master_mode
                           && engine.slave_tx_nack;          // R16
   end

   // Restart, start, stop and transmit-finished: sticky, set beats clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_r.restart <= 1'b0;
         flags_r.start   <= 1'b0;
         flags_r.stop    <= 1'b0;
         flags_r.tx_done <= 1'b0;
      end else begin
         flags_r.restart <= flags_set.restart || (flags_r.restart && !clr_all);
         flags_r.start   <= flags_set.start || (flags_r.start && !clr_all);
         flags_r.stop    <= flags_set.stop || (flags_r.stop && !clr_all);
         flags_r.tx_done <= flags_set.tx_done || (flags_r.tx_done && !clr_all);
      end
   end

   // Broadcast call: only disable, its clear read or the combined read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_r.broadcast_call_flag <= 1'b0;
      end else if (flags_set.broadcast_call_flag) begin
         flags_r.broadcast_call_flag <= 1'b1; // R4
      end else if (!enable_r || clr_gc || clr_all) begin
         flags_r.broadcast_call_flag <= 1'b0; // R5
      end
   end

   // Activity holds through idle until one of its clear events
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_r.activity <= 1'b0; // R15
      end else if (flags_set.activity) begin
         flags_r.activity <= 1'b1; // R14
      end else if (!enable_r || clr_act || clr_all) begin
         flags_r.activity <= 1'b0; // R15
      end
   end

   // Flag word straight from the flags, no mask in the path
   always_comb begin
      raw_word              = '0;
      raw_word[BIT_RESTART] = flags_r.restart;  // R1
      raw_word[BIT_GC]      = flags_r.broadcast_call_flag;
      raw_word[BIT_START]   = flags_r.start;
      raw_word[BIT_STOP]    = flags_r.stop;
      raw_word[BIT_ACT]     = flags_r.activity;
      raw_word[BIT_TXDONE]  = flags_r.tx_done;
   end

   // Received bytes of an acknowledged general call pass on like any data
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_push_r <= 1'b0;
         rx_byte_r <= 8'h00;
      end else begin
         rx_push_r <= enable_r && engine.rx_valid
                      && (gc_sess_r || addressed_r || engine.master_mode); // R6
         if (engine.rx_valid) begin
            rx_byte_r <= engine.rx_data; // R6
         end
      end
   end

   // Read mux; unmapped offsets read as zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (acc_addr)
         ADDR_CTRL: begin
            rd_data[CTRL_W-1:0] = ctrl_r;
         end
         ADDR_MASKED: begin
            rd_data[FLAG_W-1:0] = raw_word & mask_r; // R17
         end
         ADDR_MASK: begin
            rd_data[FLAG_W-1:0] = mask_r;
         end
         ADDR_RAW: begin
            rd_data[FLAG_W-1:0] = raw_word; // R1
         end
         ADDR_CLR_ALL: begin
            rd_data[0] = |raw_word;
         end
         ADDR_CLR_ACT: begin
            rd_data[0] = flags_r.activity;
         end
         ADDR_CLR_GC: begin
            rd_data[0] = flags_r.broadcast_call_flag;
         end
         ADDR_ENABLE: begin
            rd_data[0] = enable_r;
         end
         ADDR_RST_EN: begin
            rd_data[0] = rst_en_r;
         end
         default: begin
            rd_data = 32'h0000_0000;
         end
      endcase
   end

   // Bus handshake: reads answer with no wait, writes take one wait state
   // so a following read never sees a stale register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_r <= 1'b1;
         hresp_r     <= 1'b0;
         wr_pend_r   <= 1'b0;
         wr_addr_r   <= 8'h00;
      end else begin
         hresp_r <= 1'b0;
         if (wr_acc) begin
            wr_pend_r   <= 1'b1;
            wr_addr_r   <= acc_addr;
            hreadyout_r <= 1'b0;
         end else if (wr_pend_r) begin
            wr_pend_r   <= 1'b0;
            hreadyout_r <= 1'b1;
         end
      end
   end

   // Read data registered at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_acc) begin
         hrdata_r <= rd_data;
      end
   end

   // Writable registers, loaded in the wait cycle of the write
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r   <= CTRL_RST;
         mask_r   <= MASK_RST;
         enable_r <= ENABLE_RST;
         rst_en_r <= RST_EN_RST;
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            ADDR_CTRL: begin
               ctrl_r <= hwdata[CTRL_W-1:0];
            end
            ADDR_MASK: begin
               mask_r <= hwdata[FLAG_W-1:0];
            end
            ADDR_ENABLE: begin
               enable_r <= hwdata[0];
            end
            ADDR_RST_EN: begin
               rst_en_r <= hwdata[0];
            end
            default: begin
               ctrl_r <= ctrl_r;
            end
         endcase
      end
   end

   assign hrdata    = hrdata_r;
   assign hreadyout = hreadyout_r;
   assign hresp     = hresp_r;
   assign rx_push   = rx_push_r;
   assign rx_byte   = rx_byte_r;

endmodule // ire_event_status

//--- ire_pkg.sv
package ire_pkg;

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_MASKED  = 8'h2c;
   localparam logic [7:0] ADDR_MASK    = 8'h30;
   localparam logic [7:0] ADDR_RAW     = 8'h34;
   localparam logic [7:0] ADDR_CLR_ALL = 8'h40;
   localparam logic [7:0] ADDR_CLR_ACT = 8'h5c;
   localparam logic [7:0] ADDR_CLR_GC  = 8'h68;
   localparam logic [7:0] ADDR_ENABLE  = 8'h6c;
   localparam logic [7:0] ADDR_RST_EN  = 8'ha8;

   // Flag field positions in the raw and masked words
   localparam int FLAG_W      = 13;
   localparam int BIT_TXDONE  = 7;
   localparam int BIT_ACT     = 8;
   localparam int BIT_STOP    = 9;
   localparam int BIT_START   = 10;
   localparam int BIT_GC      = 11;
   localparam int BIT_RESTART = 12;

   // Configuration field positions
   localparam int CTRL_W         = 11;
   localparam int CTRL_STOP_ADDR = 7;
   localparam int CTRL_STOP_MACT = 10;

   // Reset values
   localparam logic [FLAG_W-1:0] MASK_RST   = 13'h0880;
   localparam logic [CTRL_W-1:0] CTRL_RST   = 11'h000;
   localparam logic              ENABLE_RST = 1'b0;
   localparam logic              RST_EN_RST = 1'b0;

   // AHB transfer type of a real request
   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   // Sticky event flags
   typedef struct packed {
      logic restart;
      logic broadcast_call_flag;
      logic start;
      logic stop;
      logic activity;
      logic tx_done;
   } ire_flags_t;

   // Conditions seen on the two bus lines
   typedef struct packed {
      logic start;
      logic restart;
      logic stop;
      logic busy;
   } ire_bus_ev_t;

   // Status from the protocol engine, same clock
   typedef struct packed {
      logic       master_mode;
      logic       master_active;
      logic       own_addr_match;
      logic       broadcast_call_flag_ack;
      logic       addr_after_restart;
      logic       slave_tx_nack;
      logic       rx_valid;
      logic [7:0] rx_data;
   } ire_engine_t;

endpackage

//--- ire_bus_monitor.sv
module ire_bus_monitor (
   input  wire logic                 hclk,
   input  wire logic                 hresetn,
   input  wire logic                 scl_in,
   input  wire logic                 sda_in,
   output ire_pkg::ire_bus_ev_t      bus_ev
);
   import ire_pkg::*;

   logic       scl_m_r;
   logic       scl_s_r;
   logic       sda_m_r;
   logic       sda_s_r;
   logic       scl_d_r;
   logic       sda_d_r;
   logic       busy_r;
   ire_bus_ev_t ev_r;

   // Two-stage synchronisers, first stage read by nothing else
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_m_r <= 1'b1;
         scl_s_r <= 1'b1;
         sda_m_r <= 1'b1;
         sda_s_r <= 1'b1;
      end else begin
         scl_m_r <= scl_in;
         scl_s_r <= scl_m_r;
         sda_m_r <= sda_in;
         sda_s_r <= sda_m_r;
      end
   end

   // Delayed copies for edge detection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s_r;
         sda_d_r <= sda_s_r;
      end
   end

   // Start: data falls with clock high; stop: data rises with clock high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_r   <= '0;
         busy_r <= 1'b0;
      end else begin
         ev_r.start   <= scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
         ev_r.restart <= scl_s_r && scl_d_r && sda_d_r && !sda_s_r && busy_r;
         ev_r.stop    <= scl_s_r && scl_d_r && !sda_d_r && sda_s_r;
         ev_r.busy    <= busy_r;
         if (scl_s_r && scl_d_r && sda_d_r && !sda_s_r) begin
            busy_r <= 1'b1;
         end else if (scl_s_r && scl_d_r && !sda_d_r && sda_s_r) begin
            busy_r <= 1'b0;
         end
      end
   end

   assign bus_ev = ev_r;

endmodule // ire_bus_monitor

//--- ire_event_status_properties.sv
module ire_event_status_properties
   import ire_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input ire_engine_t      engine,
   input wire logic        rx_push,
   input wire logic [7:0]  rx_byte
);
   logic rd_ok;
   logic wr_ok;

   // Accepted address phases
   assign rd_ok = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
   assign wr_ok = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response");
   a_read_nowait: assert property (rd_ok |=> hreadyout)
      else $error("read stalled");
   a_write_wait: assert property (wr_ok |=> !hreadyout ##1 hreadyout)
      else $error("write wait state wrong");
   a_rdata_hold: assert property (!rd_ok |=> $stable(hrdata))
      else $error("read data moved");
   a_raw_unused: assert property (rd_ok && haddr[7:0] == ADDR_RAW |=>
      hrdata[31:13] == 19'h0 && hrdata[6:0] == 7'h0) else $error("raw spare bits set");
   a_gc_clear_word: assert property (rd_ok && haddr[7:0] == ADDR_CLR_GC |=>
      hrdata[31:1] == 31'h0) else $error("clear word spare bits set");
   a_unmapped_zero: assert property (rd_ok && haddr[7:0] == 8'h10 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rx_forward: assert property (rx_push |->
      $past(engine.rx_valid) && rx_byte == $past(engine.rx_data)) else $error("byte not forwarded");
   a_rx_quiet: assert property (!engine.rx_valid |=> !rx_push)
      else $error("spurious push");
endmodule // ire_event_status_properties

bind ire_event_status ire_event_status_properties chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .engine(engine), .rx_push(rx_push), .rx_byte(rx_byte)
);

//--- ire_i2c_peer.sv
// Remote bus party; both lines pulled up, so released means high
module ire_i2c_peer (
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle bus, clock stands still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // Data falls while clock high; 1 ns skew keeps it off hclk edges
   task automatic start();
      #1 sda = 1'b0;
      #16 scl = 1'b0;
      #16;
   endtask

   // Repeated start from a low clock
   task automatic restart();
      #1 sda = 1'b1;
      #16 scl = 1'b1;
      #16 sda = 1'b0;
      #16 scl = 1'b0;
      #16;
   endtask

   // Data rises while clock high, then both released
   task automatic stop();
      #1 sda = 1'b0;
      #16 scl = 1'b1;
      #16 sda = 1'b1;
      #16;
   endtask
endmodule // ire_i2c_peer

//--- ire_event_status_bench.sv
module ire_event_status_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import ire_pkg::*;
   localparam logic [31:0] ST = 32'h1 << BIT_START;
   localparam logic [31:0] SP = 32'h1 << BIT_STOP;
   localparam logic [31:0] AC = 32'h1 << BIT_ACT;
   localparam logic [31:0] GC = 32'h1 << BIT_GC;
   localparam logic [31:0] RS = 32'h1 << BIT_RESTART;
   localparam logic [31:0] TD = 32'h1 << BIT_TXDONE;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl, sda, rx_push, rd_dp;
   logic [31:0] haddr, hwdata, hrdata, m;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  rx_byte;
   ire_engine_t eng;
   int          err_count, n_tests;
   logic [31:0] exp_q[$];
   logic [7:0]  rx_q[$];

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   ire_event_status dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_in(scl),
      .sda_in(sda), .engine(eng), .rx_push(rx_push), .rx_byte(rx_byte)
   );
   ire_i2c_peer peer (.scl(scl), .sda(sda));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Results appear at the end of each read data phase and on every push
   always @(posedge hclk) begin
      if (rd_dp && hreadyout) check(hrdata, exp_q.pop_front());
      if (rx_push === 1'b1) check(rx_byte, rx_q.size() ? rx_q.pop_front() : 32'h100);
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask

   // Single AHB transfer; a read notes d as the expected word
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      if (!wr) exp_q.push_back(d);
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wr ? d : 32'h0;
      rd_dp <= !wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_dp <= 1'b0;
   endtask

   // One frame on the wire with engine status around it, then flags read and cleared
   task automatic run_case(input logic [10:0] c, input logic mm, input logic ma,
                           input bit rs, input logic own, input logic gca,
                           input logic aar, input logic [31:0] e);
      bus(1'b1, ADDR_CTRL, {21'h0, c});
      eng.master_mode <= mm;
      eng.master_active <= ma;
      eng.addr_after_restart <= aar;
      peer.start();
      @(posedge hclk);
      eng.own_addr_match <= own;
      eng.broadcast_call_flag_ack <= gca;
      @(posedge hclk);
      eng.broadcast_call_flag_ack <= 1'b0;
      if (rs) peer.restart();
      cyc(2);
      eng.own_addr_match <= 1'b0;
      // Master idles before the stop, else activity would re-set after the clear
      eng.master_active <= 1'b0;
      peer.stop();
      cyc(8);
      bus(1'b0, ADDR_RAW, e);
      if (e[BIT_GC]) begin
         bus(1'b0, ADDR_CLR_GC, 32'h1);
         bus(1'b0, ADDR_RAW, e & ~GC);
      end
      bus(1'b0, ADDR_CLR_ALL, 32'h1);
      bus(1'b0, ADDR_RAW, 32'h0);
      $display("case ctrl %h done", c);
   endtask

   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      rd_dp = 1'b0;
      eng = '0;
      hresetn = 1'b0;
      err_count = 0;
      n_tests = 0;
      void'($urandom(32'ha7e6));
      cyc(16);
      hresetn <= 1'b1;
      // Reset values, a read-only write and an unmapped place
      bus(1'b0, ADDR_RAW, 32'h0);
      bus(1'b0, ADDR_MASK, {19'h0, MASK_RST});
      bus(1'b1, ADDR_RAW, 32'hffff_ffff);
      bus(1'b0, 8'h10, 32'h0);
      bus(1'b0, ADDR_RAW, 32'h0);
      bus(1'b1, ADDR_ENABLE, 32'h1);
      $display("test reset_values done");
      // Stop qualifiers, start, broadcast call and restart
      run_case(11'h000, 1'b0, 1'b0, 0, 1'b0, 1'b0, 1'b0, ST | SP | AC);
      run_case(11'h080, 1'b0, 1'b0, 0, 1'b0, 1'b0, 1'b0, ST | AC);
      run_case(11'h080, 1'b0, 1'b0, 0, 1'b1, 1'b0, 1'b0, ST | SP | AC);
      run_case(11'h080, 1'b0, 1'b0, 0, 1'b0, 1'b1, 1'b0, GC | ST | AC);
      run_case(11'h000, 1'b0, 1'b0, 1, 1'b1, 1'b0, 1'b0, ST | SP | AC);
      bus(1'b1, ADDR_RST_EN, 32'h1);
      run_case(11'h000, 1'b0, 1'b0, 1, 1'b1, 1'b0, 1'b0, RS | ST | SP | AC);
      run_case(11'h000, 1'b0, 1'b0, 1, 1'b1, 1'b0, 1'b1, ST | SP | AC);
      run_case(11'h400, 1'b1, 1'b0, 0, 1'b0, 1'b0, 1'b0, ST | AC);
      run_case(11'h400, 1'b1, 1'b1, 0, 1'b0, 1'b0, 1'b0, ST | SP | AC);
      run_case(11'h000, 1'b1, 1'b0, 0, 1'b0, 1'b0, 1'b0, ST | SP | AC);
      // Transmit finished, seen raw and through random masks
      eng.master_mode <= 1'b0;
      eng.slave_tx_nack <= 1'b1;
      @(posedge hclk);
      eng.slave_tx_nack <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         m = {19'h0, 13'($urandom)};
         bus(1'b1, ADDR_MASK, m);
         bus(1'b0, ADDR_MASKED, TD & m);
         bus(1'b0, ADDR_RAW, TD);
      end
      bus(1'b0, ADDR_CLR_ALL, 32'h1);
      $display("test tx_done_mask done");
      // Activity clear register, then disable drops broadcast and activity
      run_case(11'h000, 1'b0, 1'b0, 0, 1'b0, 1'b1, 1'b0, GC | ST | SP | AC);
      bus(1'b0, ADDR_RAW, 32'h0);
      peer.start();
      peer.stop();
      cyc(8);
      bus(1'b0, ADDR_CLR_ACT, 32'h1);
      bus(1'b0, ADDR_RAW, ST | SP);
      bus(1'b1, ADDR_CLR_ALL, 32'h0);
      peer.start();
      @(posedge hclk);
      eng.broadcast_call_flag_ack <= 1'b1;
      @(posedge hclk);
      eng.broadcast_call_flag_ack <= 1'b0;
      peer.stop();
      cyc(8);
      bus(1'b1, ADDR_ENABLE, 32'h0);
      bus(1'b0, ADDR_RAW, ST | SP);
      bus(1'b1, ADDR_ENABLE, 32'h1);
      bus(1'b0, ADDR_CLR_ALL, 32'h1);
      $display("test clears done");
      // A byte outside any session is dropped; bytes after a broadcast call pass on
      eng.master_mode <= 1'b0;
      eng.rx_data <= 8'h5a;
      eng.rx_valid <= 1'b1;
      @(posedge hclk);
      eng.rx_valid <= 1'b0;
      peer.start();
      @(posedge hclk);
      eng.broadcast_call_flag_ack <= 1'b1;
      @(posedge hclk);
      eng.broadcast_call_flag_ack <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         m = $urandom;
         eng.rx_data <= m[7:0];
         eng.rx_valid <= 1'b1;
         rx_q.push_back(m[7:0]);
         @(posedge hclk);
      end
      eng.rx_valid <= 1'b0;
      peer.stop();
      cyc(8);
      check(rx_q.size(), 32'h0);
      bus(1'b0, ADDR_CLR_GC, 32'h1);
      $display("test receive done");
      stop_test();
   end

   // Whole run needs well under 20000 cycles
   initial begin
      #200000;
      err_count++;
      stop_test();
   end
endmodule // ire_event_status_bench
